// file: core/ers_defines.svh
// Named constants for the error routing and synchronization block
`ifndef ERS_DEFINES_SVH
`define ERS_DEFINES_SVH

// Exception level codes
`define ERS_EL0 2'h0
`define ERS_EL1 2'h1
`define ERS_EL2 2'h2
`define ERS_EL3 2'h3

// Vector offsets for the narrow execution state
`define ERS_VEC_NONE 5'h00
`define ERS_VEC_MON_PREFETCH 5'h0C
`define ERS_VEC_MON_DATA 5'h10
`define ERS_VEC_HYP 5'h14

// Widths and reset values
`define ERS_VEC_W 5
`define ERS_EL_W 2
`define ERS_NUM_EL 4
`define ERS_SRC_NONE 5'h00

`endif

// file: core/ers_pkg.sv
// Types shared by the error routing and synchronization block
package ers_pkg;

  // Class of the exception being routed
  typedef enum logic [2:0] {
    ERS_CLS_SYSTEM_ERROR_INTERRUPT = 3'b001,
    ERS_CLS_DATA_ABORT = 3'b010,
    ERS_CLS_PREFETCH_ABORT = 3'b100
  } ers_class_e;

  // Target mode in the narrow execution state
  typedef enum logic [2:0] {
    ERS_MODE_ABORT = 3'b001,
    ERS_MODE_HYP = 3'b010,
    ERS_MODE_MONITOR = 3'b100
  } ers_mode_e;

  // Source of an error synchronization event, one bit per source
  typedef logic [4:0] ers_src_t;

endpackage

// file: core/ers_route32.sv
// Target mode and vector offset selection for the narrow execution state
`include "ers_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ers_route32
  import ers_pkg::*;
(
  // Exception being routed
  input wire logic [1:0] curEl,
  input wire ers_class_e excClass,
  // Routing controls
  input wire logic el3Impl,
  input wire logic el3Narrow,
  input wire logic monitorExtAbortRoute,
  input wire logic el2Impl,
  input wire logic el2Narrow,
  input wire logic nonSecure,
  input wire logic hyp32AsyncAbortRoute,
  input wire logic hyp32GeneralTrap,
  input wire logic hyp32SyncExtAbortRoute,
  // Decision
  output ers_mode_e targetMode,
  output logic [4:0] vecOffset
);

  logic fromLow;

  assign fromLow = (curEl == `ERS_EL0) || (curEl == `ERS_EL1);

  // Monitor override first, then Hyp overrides, then the default mode
  always_comb
  begin
    targetMode = (curEl == `ERS_EL2) ? ERS_MODE_HYP : ERS_MODE_ABORT; // [RQ5]
    vecOffset = `ERS_VEC_NONE;
    if (el3Impl && el3Narrow && monitorExtAbortRoute)
    begin
      targetMode = ERS_MODE_MONITOR;
      if (excClass == ERS_CLS_PREFETCH_ABORT)
      begin
        vecOffset = `ERS_VEC_MON_PREFETCH; // [RQ7]
      end
      else
      begin
        vecOffset = `ERS_VEC_MON_DATA; // [RQ6]
      end
    end
    else if (el2Impl && el2Narrow && nonSecure && fromLow)
    begin
      if ((excClass == ERS_CLS_SYSTEM_ERROR_INTERRUPT) && (hyp32AsyncAbortRoute || hyp32GeneralTrap))
      begin
        targetMode = ERS_MODE_HYP; // [RQ8]
        vecOffset = `ERS_VEC_HYP;
      end
      if ((excClass != ERS_CLS_SYSTEM_ERROR_INTERRUPT) && (hyp32SyncExtAbortRoute || hyp32GeneralTrap))
      begin
        targetMode = ERS_MODE_HYP; // [RQ9]
        vecOffset = `ERS_VEC_HYP;
      end
    end
  end

endmodule

`default_nettype wire

// file: core/ers_route64.sv
// Target exception level selection for the wide execution state
`include "ers_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ers_route64
  import ers_pkg::*;
(
  // Exception being routed
  input wire logic [1:0] curEl,
  input wire ers_class_e excClass,
  // Routing controls
  input wire logic el3Impl,
  input wire logic el3ExtAbortRoute,
  input wire logic el2Impl,
  input wire logic el2Enabled,
  input wire logic hypAsyncAbortRoute,
  input wire logic hypGeneralTrap,
  input wire logic hypSyncExtAbortRoute,
  // Decision
  output logic [1:0] targetEl
);

  logic fromLow;

  assign fromLow = (curEl == `ERS_EL0) || (curEl == `ERS_EL1);

  // EL3 override first, then the EL2 overrides, then the default level
  always_comb
  begin
    targetEl = fromLow ? `ERS_EL1 : curEl; // [RQ1]
    if (el3Impl && el3ExtAbortRoute)
    begin
      targetEl = `ERS_EL3; // [RQ2]
    end
    else if (el2Impl && el2Enabled && fromLow)
    begin
      if ((excClass == ERS_CLS_SYSTEM_ERROR_INTERRUPT) && (hypAsyncAbortRoute || hypGeneralTrap))
      begin
        targetEl = `ERS_EL2; // [RQ3]
      end
      if ((excClass != ERS_CLS_SYSTEM_ERROR_INTERRUPT) && (hypSyncExtAbortRoute || hypGeneralTrap))
      begin
        targetEl = `ERS_EL2; // [RQ4]
      end
    end
  end

endmodule

`default_nettype wire

// file: core/ers_top.sv
// Error exception routing and error synchronization event generation
`include "ers_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1: Wide state default: EL0/EL1 go to EL1, EL2 to EL2, EL3 to EL3.
// RQ2: EL3 implemented with its abort routing bit set sends everything to EL3.
// RQ3: Else with EL2 enabled, low-level system errors go to EL2 on async route or trap.
// RQ4: Else with EL2 enabled, low-level sync aborts go to EL2 on sync route or trap.
// RQ5: Narrow state default: Abort mode from EL0/EL1/EL3, Hyp mode from EL2.
// RQ6: Narrow EL3 routing sends system errors and data aborts to Monitor at 0x10.
// RQ7: Narrow EL3 routing sends prefetch aborts to Monitor at 0x0C.
// RQ8: Narrow non-secure EL2 takes low system errors to Hyp at 0x14 on route or trap.
// RQ9: Narrow non-secure EL2 takes low sync aborts to Hyp at 0x14 on route or trap.
// RQ10: Every barrier instruction produces a synchronization event.
// RQ11: Wide exception entry produces an event when enabled or EL3 double-fault set.
// RQ12: Wide exception return produces an event when enabled or EL3 double-fault set.
// RQ13: Debug change-state and debug return follow entry and return conditions.
// RQ14: Barrier records a masked pending system error and clears its pending state.
// RQ15: Only errors from this element's own instructions count as synchronized.
// RQ16: Unmasked or synchronous case: cause follows event, older work complete.
// RQ17: Masked async case with nothing pending: cause follows event, older work done.
// RQ18: Not pending at completion exactly when the pending flag later reads zero.
// RQ19: Routing decision is presented in the same cycle as the request.
module ers_top
  import ers_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Routing request from exception entry
  input wire logic routeReq,
  input wire logic routeWide,
  input wire ers_class_e excClass,
  input wire logic [1:0] curEl,
  // Implementation and state controls
  input wire logic el3Impl,
  input wire logic el3Narrow,
  input wire logic el2Impl,
  input wire logic el2Enabled,
  input wire logic el2Narrow,
  input wire logic nonSecure,
  // Wide state routing bits
  input wire logic el3ExtAbortRoute,
  input wire logic hypAsyncAbortRoute,
  input wire logic hypGeneralTrap,
  input wire logic hypSyncExtAbortRoute,
  // Narrow state routing bits
  input wire logic monitorExtAbortRoute,
  input wire logic hyp32AsyncAbortRoute,
  input wire logic hyp32GeneralTrap,
  input wire logic hyp32SyncExtAbortRoute,
  // Routing decision
  output logic [1:0] routeTargetEl,
  output ers_mode_e routeMode,
  output logic [4:0] routeVecOffset,
  // Feature presence and synchronization enables
  input wire logic implicitErrSyncFeature,
  input wire logic doubleFaultFeature,
  input wire logic [3:0] implicitErrSyncEnable,
  input wire logic nonmaskableExtAbortBit,
  input wire logic el3NonmaskableAbortBit,
  // Instruction and exception events from the pipeline
  input wire logic errorSyncBarrierInstr,
  input wire logic excEntry,
  input wire logic excEntryWide,
  input wire logic [1:0] excEntryEl,
  input wire logic excReturn,
  input wire logic excReturnWide,
  input wire logic [1:0] excReturnEl,
  input wire logic debugState,
  input wire logic debugChangeStateInstr,
  input wire logic [1:0] debugChangeStateEl,
  input wire logic debugReturnInstr,
  input wire logic [1:0] debugReturnEl,
  // Error reporting from the pipeline
  input wire logic serrorMasked,
  input wire logic errRaise,
  input wire logic errSameElement,
  input wire logic errTaken,
  input wire logic errTakenSync,
  input wire logic errCauseAfterEvent,
  input wire logic olderInstrComplete,
  // Synchronization event outputs
  output logic errSyncEvent,
  output ers_src_t errSyncSource,
  output logic deferRecord,
  output logic pendingAsyncErrorFlag,
  // Synchronization check outputs
  output logic errCheckDone,
  output logic errSynchronized
);

  logic [1:0] el64;
  ers_mode_e mode32;
  logic [4:0] vec32;
  ers_src_t next_src;
  logic next_event;
  logic barrierClear;
  logic pendRaise;
  logic maskAtEvent;
  logic pendAtCompletion;
  logic next_synced;

  // Implicit synchronization condition shared by entry, return and debug
  function automatic logic implicitFires(
    input logic [1:0] el,
    input logic [3:0] enable,
    input logic nmea
  );
    logic enBit;
    enBit = enable[el];
    implicitFires = implicitErrSyncFeature &&
                    (enBit || (doubleFaultFeature && (el == `ERS_EL3) && nmea));
  endfunction

  // Wide state routing
  ers_route64 uRoute64 (
    .curEl(curEl),
    .excClass(excClass),
    .el3Impl(el3Impl),
    .el3ExtAbortRoute(el3ExtAbortRoute),
    .el2Impl(el2Impl),
    .el2Enabled(el2Enabled),
    .hypAsyncAbortRoute(hypAsyncAbortRoute),
    .hypGeneralTrap(hypGeneralTrap),
    .hypSyncExtAbortRoute(hypSyncExtAbortRoute),
    .targetEl(el64)
  );

  // Narrow state routing
  ers_route32 uRoute32 (
    .curEl(curEl),
    .excClass(excClass),
    .el3Impl(el3Impl),
    .el3Narrow(el3Narrow),
    .monitorExtAbortRoute(monitorExtAbortRoute),
    .el2Impl(el2Impl),
    .el2Narrow(el2Narrow),
    .nonSecure(nonSecure),
    .hyp32AsyncAbortRoute(hyp32AsyncAbortRoute),
    .hyp32GeneralTrap(hyp32GeneralTrap),
    .hyp32SyncExtAbortRoute(hyp32SyncExtAbortRoute),
    .targetMode(mode32),
    .vecOffset(vec32)
  );

  // Decision follows the request combinationally so entry logic needs no wait
  always_comb
  begin
    routeTargetEl = `ERS_EL0;
    routeMode = ERS_MODE_ABORT;
    routeVecOffset = `ERS_VEC_NONE;
    if (routeReq && routeWide)
    begin
      routeTargetEl = el64; // [RQ19]
    end
    else if (routeReq)
    begin
      routeMode = mode32; // [RQ19]
      routeVecOffset = vec32;
    end
  end

  // Collect event sources for this cycle
  always_comb
  begin
    next_src = `ERS_SRC_NONE;
    next_src[0] = errorSyncBarrierInstr; // [RQ10]
    next_src[1] = excEntry && excEntryWide &&
                  implicitFires(excEntryEl, implicitErrSyncEnable,
                                nonmaskableExtAbortBit); // [RQ11]
    next_src[2] = excReturn && excReturnWide &&
                  implicitFires(excReturnEl, implicitErrSyncEnable,
                                el3NonmaskableAbortBit); // [RQ12]
    next_src[3] = debugState && debugChangeStateInstr &&
                  implicitFires(debugChangeStateEl, implicitErrSyncEnable,
                                nonmaskableExtAbortBit); // [RQ13]
    next_src[4] = debugState && debugReturnInstr &&
                  implicitFires(debugReturnEl, implicitErrSyncEnable,
                                el3NonmaskableAbortBit); // [RQ13]
  end

  assign next_event = |next_src;

  // Event pulse and source register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      errSyncEvent <= 1'b0;
      errSyncSource <= `ERS_SRC_NONE;
    end
    else
    begin
      errSyncEvent <= next_event;
      errSyncSource <= next_src;
    end
  end

  // Only errors from this element's own instructions become pending here
  assign pendRaise = errRaise && errSameElement; // [RQ15]
  assign barrierClear = errorSyncBarrierInstr && serrorMasked && pendingAsyncErrorFlag;

  // Pending flag: a new error in the clearing cycle is kept
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pendingAsyncErrorFlag <= 1'b0;
    end
    else if (pendRaise)
    begin
      pendingAsyncErrorFlag <= 1'b1;
    end
    else if (barrierClear)
    begin
      pendingAsyncErrorFlag <= 1'b0; // [RQ14]
    end
  end

  // Record pulse for the deferred syndrome store
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      deferRecord <= 1'b0;
    end
    else
    begin
      deferRecord <= barrierClear; // [RQ14]
    end
  end

  // Mask and pending state captured at each event
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      maskAtEvent <= 1'b0;
      pendAtCompletion <= 1'b0;
    end
    else if (next_event)
    begin
      maskAtEvent <= serrorMasked;
      // A raise in the clearing cycle wins, so the error is still pending afterwards
      pendAtCompletion <= pendRaise || (pendingAsyncErrorFlag && !barrierClear); // [RQ18]
    end
  end

  // Synchronized check on a taken error
  always_comb
  begin
    next_synced = errSameElement && errCauseAfterEvent && olderInstrComplete; // [RQ15]
    if (errTakenSync || !maskAtEvent)
    begin
      next_synced = next_synced; // [RQ16]
    end
    else
    begin
      next_synced = next_synced && !pendAtCompletion; // [RQ17]
    end
  end

  // Check result register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      errCheckDone <= 1'b0;
      errSynchronized <= 1'b0;
    end
    else
    begin
      errCheckDone <= errTaken;
      errSynchronized <= errTaken && next_synced;
    end
  end

  // Named sequences for the multi-step behaviours
  sequence barrierMaskedPending;
    errorSyncBarrierInstr && serrorMasked && pendingAsyncErrorFlag && !pendRaise;
  endsequence

  sequence recordAndClear;
    deferRecord && !pendingAsyncErrorFlag;
  endsequence

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rst_b);

  route64_default_a: assert property ( // [RQ1]
    (routeReq && routeWide && !el3ExtAbortRoute && !el2Enabled && (curEl == `ERS_EL0))
      |-> (routeTargetEl == `ERS_EL1))
    else $error("Default wide route from EL0 is not EL1");

  route64_el3_a: assert property ( // [RQ2]
    (routeReq && routeWide && el3Impl && el3ExtAbortRoute) |-> (routeTargetEl == `ERS_EL3))
    else $error("EL3 abort routing not honoured");

  route64_system_error_interrupt_a: assert property ( // [RQ3]
    (routeReq && routeWide && !(el3Impl && el3ExtAbortRoute) && el2Impl && el2Enabled &&
     (curEl == `ERS_EL1) && (excClass == ERS_CLS_SYSTEM_ERROR_INTERRUPT) && hypGeneralTrap)
      |-> (routeTargetEl == `ERS_EL2))
    else $error("System error not routed to EL2");

  route64_sync_a: assert property ( // [RQ4]
    (routeReq && routeWide && !(el3Impl && el3ExtAbortRoute) && el2Impl && el2Enabled &&
     (curEl == `ERS_EL0) && (excClass == ERS_CLS_DATA_ABORT) && hypSyncExtAbortRoute)
      |-> (routeTargetEl == `ERS_EL2))
    else $error("Sync abort not routed to EL2");

  route32_default_a: assert property ( // [RQ5]
    (routeReq && !routeWide && !monitorExtAbortRoute && !el2Narrow)
      |-> (routeMode == ((curEl == `ERS_EL2) ? ERS_MODE_HYP : ERS_MODE_ABORT)))
    else $error("Default narrow mode wrong");

  monitor_data_a: assert property ( // [RQ6]
    (routeReq && !routeWide && el3Impl && el3Narrow && monitorExtAbortRoute &&
     (excClass != ERS_CLS_PREFETCH_ABORT))
      |-> (routeMode == ERS_MODE_MONITOR) && (routeVecOffset == `ERS_VEC_MON_DATA))
    else $error("Monitor data vector wrong");

  monitor_prefetch_a: assert property ( // [RQ7]
    (routeReq && !routeWide && el3Impl && el3Narrow && monitorExtAbortRoute &&
     (excClass == ERS_CLS_PREFETCH_ABORT))
      |-> (routeVecOffset == `ERS_VEC_MON_PREFETCH))
    else $error("Monitor prefetch vector wrong");

  hyp_vector_a: assert property ( // [RQ8]
    (routeReq && !routeWide && !(el3Impl && el3Narrow && monitorExtAbortRoute) &&
     el2Impl && el2Narrow && nonSecure && (curEl == `ERS_EL1) &&
     (excClass == ERS_CLS_SYSTEM_ERROR_INTERRUPT) && hyp32AsyncAbortRoute)
      |-> (routeMode == ERS_MODE_HYP) && (routeVecOffset == `ERS_VEC_HYP))
    else $error("Hyp system error vector wrong");

  barrier_event_a: assert property ( // [RQ10]
    errorSyncBarrierInstr |=> errSyncEvent && errSyncSource[0])
    else $error("Barrier gave no synchronization event");

  entry_event_a: assert property ( // [RQ11]
    (excEntry && excEntryWide && implicitErrSyncFeature && (excEntryEl == `ERS_EL3) &&
     doubleFaultFeature && nonmaskableExtAbortBit) |=> errSyncEvent)
    else $error("EL3 double-fault entry gave no event");

  no_feature_a: assert property ( // [RQ12]
    (!implicitErrSyncFeature && !errorSyncBarrierInstr) |=> !errSyncEvent)
    else $error("Event without feature or barrier");

  barrier_record_a: assert property ( // [RQ14]
    barrierMaskedPending |=> recordAndClear)
    else $error("Masked pending error not recorded and cleared");

  raise_wins_a: assert property ( // [RQ18]
    (pendRaise && barrierClear) |=> pendingAsyncErrorFlag && deferRecord)
    else $error("Pending error lost on clear");

  foreign_error_a: assert property ( // [RQ15]
    (errTaken && !errSameElement) |=> errCheckDone && !errSynchronized)
    else $error("Foreign error marked synchronized");

endmodule

`default_nettype wire

// file: tb/ers_dbg_model.sv
// Debug-state pipeline model that issues debug instructions
`timescale 1ns/1ps
`default_nettype none

module ers_dbg_model
(
  // Requests from the bench
  input wire logic dbgOn,
  input wire logic chgReq,
  input wire logic retReq,
  // Debug-state pipeline outputs
  output logic debugState,
  output logic debugChangeStateInstr,
  output logic debugReturnInstr
);
  // Debug instructions only ever execute while in debug state
  assign debugState = dbgOn;
  assign debugChangeStateInstr = dbgOn & chgReq;
  assign debugReturnInstr = dbgOn & retReq;
endmodule
`default_nettype wire

// file: tb/test_ers_top.sv
// Self-checking bench for the error routing and synchronization block
`include "ers_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module test_ers_top;
  import ers_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, routeReq = 1'b0, routeWide = 1'b0;
  ers_class_e excClass = ERS_CLS_SYSTEM_ERROR_INTERRUPT;
  logic [1:0] curEl = 2'h0, excEntryEl = 2'h0, excReturnEl = 2'h0;
  logic [1:0] debugChangeStateEl = 2'h0, debugReturnEl = 2'h0, routeTargetEl, eEl;
  logic el3Impl = 1'b0, el3Narrow = 1'b0, el2Impl = 1'b0, el2Enabled = 1'b0;
  logic el2Narrow = 1'b0, nonSecure = 1'b0, el3ExtAbortRoute = 1'b0;
  logic hypAsyncAbortRoute = 1'b0, hypGeneralTrap = 1'b0, hypSyncExtAbortRoute = 1'b0;
  logic monitorExtAbortRoute = 1'b0, hyp32AsyncAbortRoute = 1'b0;
  logic hyp32GeneralTrap = 1'b0, hyp32SyncExtAbortRoute = 1'b0;
  logic implicitErrSyncFeature = 1'b0, doubleFaultFeature = 1'b0;
  logic nonmaskableExtAbortBit = 1'b0, el3NonmaskableAbortBit = 1'b0;
  logic [3:0] implicitErrSyncEnable = 4'h0;
  logic errorSyncBarrierInstr = 1'b0, excEntry = 1'b0, excEntryWide = 1'b0;
  logic excReturn = 1'b0, excReturnWide = 1'b0, dbgOn = 1'b0, chgReq = 1'b0, retReq = 1'b0;
  logic serrorMasked = 1'b0, errRaise = 1'b0, errSameElement = 1'b0, errTaken = 1'b0;
  logic errTakenSync = 1'b0, errCauseAfterEvent = 1'b0, olderInstrComplete = 1'b0;
  logic debugState, debugChangeStateInstr, debugReturnInstr, errSyncEvent, deferRecord;
  logic pendingAsyncErrorFlag, errCheckDone, errSynchronized;
  ers_mode_e routeMode, eMode;
  logic [4:0] routeVecOffset, eVec;
  ers_src_t errSyncSource, expSrc;
  int fail_count = 0, checks = 0, cycles = 0, i;

  // Clock and run limit
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  // Design and debug pipeline model
  ers_top dut (.mclk, .rst_b, .routeReq, .routeWide, .excClass, .curEl, .el3Impl, .el3Narrow,
    .el2Impl, .el2Enabled, .el2Narrow, .nonSecure, .el3ExtAbortRoute, .hypAsyncAbortRoute,
    .hypGeneralTrap, .hypSyncExtAbortRoute, .monitorExtAbortRoute, .hyp32AsyncAbortRoute,
    .hyp32GeneralTrap, .hyp32SyncExtAbortRoute, .routeTargetEl, .routeMode, .routeVecOffset,
    .implicitErrSyncFeature, .doubleFaultFeature, .implicitErrSyncEnable,
    .nonmaskableExtAbortBit, .el3NonmaskableAbortBit, .errorSyncBarrierInstr, .excEntry,
    .excEntryWide, .excEntryEl, .excReturn, .excReturnWide, .excReturnEl, .debugState,
    .debugChangeStateInstr, .debugChangeStateEl, .debugReturnInstr, .debugReturnEl,
    .serrorMasked, .errRaise, .errSameElement, .errTaken, .errTakenSync, .errCauseAfterEvent,
    .olderInstrComplete, .errSyncEvent, .errSyncSource, .deferRecord, .pendingAsyncErrorFlag,
    .errCheckDone, .errSynchronized);
  ers_dbg_model partner (.dbgOn, .chgReq, .retReq, .debugState, .debugChangeStateInstr,
    .debugReturnInstr);

  // Expected routing decision from the current inputs
  function automatic void exp_route();
    logic low, serr, hit;
    low = (curEl < 2'h2);
    serr = (excClass == ERS_CLS_SYSTEM_ERROR_INTERRUPT);
    eEl = 2'h0;
    eMode = ERS_MODE_ABORT;
    eVec = `ERS_VEC_NONE;
    if (routeReq && routeWide)
    begin
      hit = serr ? (hypAsyncAbortRoute | hypGeneralTrap) : (hypSyncExtAbortRoute | hypGeneralTrap);
      if (el3Impl && el3ExtAbortRoute) eEl = 2'h3;
      else if (el2Impl && el2Enabled && low && hit) eEl = 2'h2;
      else eEl = low ? 2'h1 : curEl;
    end
    else if (routeReq)
    begin
      hit = serr ? (hyp32AsyncAbortRoute | hyp32GeneralTrap) :
        (hyp32SyncExtAbortRoute | hyp32GeneralTrap);
      if (el3Impl && el3Narrow && monitorExtAbortRoute)
      begin
        eMode = ERS_MODE_MONITOR;
        eVec = (excClass == ERS_CLS_PREFETCH_ABORT) ? `ERS_VEC_MON_PREFETCH : `ERS_VEC_MON_DATA;
      end
      else if (el2Impl && el2Narrow && nonSecure && low && hit)
      begin
        eMode = ERS_MODE_HYP;
        eVec = `ERS_VEC_HYP;
      end
      else if (curEl == 2'h2) eMode = ERS_MODE_HYP;
    end
  endfunction

  // Whether entry or return at a level yields an event
  function automatic logic ok(logic [1:0] el, logic nm);
    return implicitErrSyncFeature & (implicitErrSyncEnable[el] |
      (doubleFaultFeature & (el == 2'h3) & nm));
  endfunction

  // Expected event sources for this cycle's pulses
  function automatic ers_src_t ev_src();
    ers_src_t s;
    s[0] = errorSyncBarrierInstr;
    s[1] = excEntry & excEntryWide & ok(excEntryEl, nonmaskableExtAbortBit);
    s[2] = excReturn & excReturnWide & ok(excReturnEl, el3NonmaskableAbortBit);
    s[3] = debugChangeStateInstr & ok(debugChangeStateEl, nonmaskableExtAbortBit);
    s[4] = debugReturnInstr & ok(debugReturnEl, el3NonmaskableAbortBit);
    return s;
  endfunction

  // Comparisons, one per kind of result
  task automatic chk_route();
    checks++;
    if (routeTargetEl !== eEl || routeMode !== eMode || routeVecOffset !== eVec)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h %h %h exp %h %h %h", $time, routeTargetEl, routeMode,
        routeVecOffset, eEl, eMode, eVec);
    end
  endtask
  task automatic chk_ev();
    checks++;
    if ({errSyncEvent, errSyncSource} !== {|expSrc, expSrc})
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, {errSyncEvent, errSyncSource},
        {|expSrc, expSrc});
    end
  endtask
  task automatic chk_bit(logic got, logic exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Pipeline stimulus helpers
  task automatic raise(logic same);
    @(negedge mclk);
    errRaise = 1'b1;
    errSameElement = same;
    @(negedge mclk);
    errRaise = 1'b0;
  endtask
  task automatic ev(logic bar, logic mask);
    @(negedge mclk);
    serrorMasked = mask;
    errorSyncBarrierInstr = bar;
    excEntry = !bar;
    @(negedge mclk);
    errorSyncBarrierInstr = 1'b0;
    excEntry = 1'b0;
  endtask
  task automatic take(logic s, logic a, logic o, logic y, logic e);
    @(negedge mclk);
    errTaken = 1'b1;
    errSameElement = s;
    errCauseAfterEvent = a;
    olderInstrComplete = o;
    errTakenSync = y;
    @(negedge mclk);
    errTaken = 1'b0;
    chk_bit(errCheckDone, 1'b1);
    chk_bit(errSynchronized, e);
  endtask

  // Closing report
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    void'($urandom(21160));
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    // Random routing requests, wide and narrow, every class
    for (i = 0; i < 400; i++)
    begin
      @(negedge mclk);
      {el3Impl, el3Narrow, el2Impl, el2Enabled, el2Narrow, nonSecure} = 6'($urandom);
      {el3ExtAbortRoute, hypAsyncAbortRoute, hypGeneralTrap, hypSyncExtAbortRoute} = 4'($urandom);
      {monitorExtAbortRoute, hyp32AsyncAbortRoute, hyp32GeneralTrap} = 3'($urandom);
      {hyp32SyncExtAbortRoute, routeWide, curEl} = 4'($urandom);
      routeReq = ($urandom % 4) != 0;
      excClass = (i % 3 == 0) ? ERS_CLS_SYSTEM_ERROR_INTERRUPT : (i % 3 == 1) ? ERS_CLS_DATA_ABORT :
        ERS_CLS_PREFETCH_ABORT;
      #1;
      exp_route();
      chk_route();
    end
    // Random back-to-back event sources
    for (i = 0; i < 300; i++)
    begin
      @(negedge mclk);
      if (i > 0) chk_ev();
      {implicitErrSyncFeature, doubleFaultFeature, implicitErrSyncEnable} = 6'($urandom);
      {nonmaskableExtAbortBit, el3NonmaskableAbortBit, serrorMasked, dbgOn} = 4'($urandom);
      {excEntry, excEntryWide, excReturn, excReturnWide, chgReq, retReq} = 6'($urandom);
      {excEntryEl, excReturnEl, debugChangeStateEl, debugReturnEl} = 8'($urandom);
      errorSyncBarrierInstr = ($urandom % 3) == 0;
      #1;
      expSrc = ev_src();
    end
    @(negedge mclk);
    chk_ev();
    {errorSyncBarrierInstr, excEntry, excReturn, chgReq, retReq} = 5'h00;
    implicitErrSyncFeature = 1'b1;
    implicitErrSyncEnable = 4'hF;
    {excEntryWide, excEntryEl} = 3'h5;
    // Pending flag, barrier record and clear
    raise(1'b0);
    chk_bit(pendingAsyncErrorFlag, 1'b0);
    raise(1'b1);
    chk_bit(pendingAsyncErrorFlag, 1'b1);
    ev(1'b1, 1'b0);
    chk_bit(deferRecord, 1'b0);
    chk_bit(pendingAsyncErrorFlag, 1'b1);
    ev(1'b1, 1'b1);
    chk_bit(deferRecord, 1'b1);
    chk_bit(pendingAsyncErrorFlag, 1'b0);
    // Synchronization checks after a masked event with nothing pending
    take(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    take(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    take(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    take(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    take(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    // Masked entry event while an error stays pending
    raise(1'b1);
    ev(1'b0, 1'b1);
    take(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    take(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    // Unmasked barrier event
    ev(1'b1, 1'b0);
    take(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    // Raise in the clearing cycle of a masked barrier: the set wins, record still pulses
    @(negedge mclk);
    {errRaise, serrorMasked, errorSyncBarrierInstr} = 3'h7;
    @(negedge mclk);
    {errRaise, errorSyncBarrierInstr} = 2'h0;
    chk_bit(deferRecord, 1'b1);
    chk_bit(pendingAsyncErrorFlag, 1'b1);
    take(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
